// *** shared/nifw_pkg.sv ***
package nifw_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_BUS_OPTIONS = 8'h20;
  localparam logic [7:0] OFS_ID_UPPER = 8'h24;
  localparam logic [7:0] OFS_ID_LOWER = 8'h28;
  localparam logic [7:0] OFS_ROM_BASE = 8'h34;
  localparam logic [7:0] OFS_LOG_LOWER = 8'h38;
  localparam logic [7:0] OFS_LOG_UPPER = 8'h3C;
  localparam logic [7:0] OFS_EVENT_SET = 8'h80;
  localparam logic [7:0] OFS_EVENT_CLEAR = 8'h84;
  // Field positions and rate field width
  localparam int EVENT_FAILED_WRITE_BIT = 8;
  localparam int ROM_BASE_LSB = 10;
  localparam int SPD_W = 3;
  // Link rate codes
  localparam logic [2:0] SPD_100 = 3'h0;
  localparam logic [2:0] SPD_200 = 3'h1;
  localparam logic [2:0] SPD_400 = 3'h2;
  localparam logic [2:0] SPD_RESET = SPD_400;
  // Reset values
  localparam logic [31:0] ID_RESET = 32'h0;
  localparam logic [31:0] ROM_BASE_RESET = 32'h0;
  // Configuration ROM window on the serial bus
  localparam logic [47:0] ROM_SPACE_LO = 48'hFFFF_F000_0400;
  localparam logic [47:0] ROM_SPACE_HI = 48'hFFFF_F000_07FF;
  localparam logic [7:0] ROM_LOCAL_QUADLETS = 8'h05;
  // Failed-write queue
  localparam int LOG_DEPTH = 4;
endpackage : nifw_pkg

// *** verilog/nifw_regs.sv ***
`timescale 1ns/10ps
module nifw_regs #(
  parameter int DEPTH = nifw_pkg::LOG_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic soft_rst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic spd_write_protect_i,
  input wire logic eeprom_spd_load_i,
  input wire logic [2:0] eeprom_spd_i,
  input wire logic eeprom_id_load_i,
  input wire logic [31:0] eeprom_id_upper_i,
  input wire logic [31:0] eeprom_id_lower_i,
  input wire logic rx_pkt_valid_i,
  input wire logic [2:0] rx_pkt_spd_i,
  output logic rx_reject_o,
  output logic [2:0] link_spd_o,
  input wire logic rom_req_i,
  input wire logic rom_quadlet_read_i,
  input wire logic [47:0] rom_offset_i,
  output logic rom_fetch_o,
  output logic [31:0] rom_host_addr_o,
  output logic rom_local_o,
  output logic [2:0] rom_local_index_o,
  output logic rom_type_error_o,
  input wire logic fw_fail_i,
  input wire logic [15:0] fw_requester_i,
  input wire logic [47:0] fw_dest_i,
  output logic fw_drop_o,
  output logic failed_write_event_o
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] DEPTH_C = (PW+1)'(DEPTH);
  logic [2:0] link_spd, next_link_spd;
  logic [31:0] node_identity_upper, next_node_identity_upper;
  logic [31:0] node_identity_lower, next_node_identity_lower;
  logic id_upper_loaded, next_id_upper_loaded;
  logic id_lower_loaded, next_id_lower_loaded;
  logic [31:10] rom_image_base_field, next_rom_image_base_field;
  logic [31:0] rdata, next_rdata;
  logic rvalid, next_rvalid;
  logic rx_reject, next_rx_reject;
  logic wr_spd, wr_up, wr_lo, wr_rom, clr_event;
  assign wr_spd = reg_wr_i && reg_addr_i == nifw_pkg::OFS_BUS_OPTIONS;
  assign wr_up = reg_wr_i && reg_addr_i == nifw_pkg::OFS_ID_UPPER;
  assign wr_lo = reg_wr_i && reg_addr_i == nifw_pkg::OFS_ID_LOWER;
  assign wr_rom = reg_wr_i && reg_addr_i == nifw_pkg::OFS_ROM_BASE;
  assign clr_event = reg_wr_i && reg_addr_i == nifw_pkg::OFS_EVENT_CLEAR
                     && reg_wdata_i[nifw_pkg::EVENT_FAILED_WRITE_BIT];
  // Failed-write queue state
  logic [15:0] q_req [DEPTH];
  logic [47:0] q_dest [DEPTH];
  logic [15:0] next_q_req [DEPTH];
  logic [47:0] next_q_dest [DEPTH];
  logic [PW-1:0] head, next_head, tail, next_tail;
  logic [PW:0] count, next_count;
  logic event_flag, next_event_flag;
  logic fw_drop, next_fw_drop;
  // Configuration and identity registers
  always_comb begin
    next_link_spd = link_spd;
    next_node_identity_upper = node_identity_upper;
    next_node_identity_lower = node_identity_lower;
    next_id_upper_loaded = id_upper_loaded;
    next_id_lower_loaded = id_lower_loaded;
    next_rom_image_base_field = rom_image_base_field;
    next_rx_reject = rx_pkt_valid_i && (rx_pkt_spd_i > link_spd);
    if (eeprom_spd_load_i && eeprom_spd_i <= nifw_pkg::SPD_400) begin
      next_link_spd = eeprom_spd_i;
    end else if (wr_spd && !spd_write_protect_i && reg_wdata_i[2:0] <= link_spd) begin
      next_link_spd = reg_wdata_i[2:0];
    end
    if (eeprom_id_load_i && !id_upper_loaded) begin
      next_node_identity_upper = eeprom_id_upper_i;
      next_id_upper_loaded = 1'b1;
    end else if (wr_up && !id_upper_loaded) begin
      next_node_identity_upper = reg_wdata_i;
      next_id_upper_loaded = 1'b1;
    end
    if (eeprom_id_load_i && !id_lower_loaded) begin
      next_node_identity_lower = eeprom_id_lower_i;
      next_id_lower_loaded = 1'b1;
    end else if (wr_lo && !id_lower_loaded) begin
      next_node_identity_lower = reg_wdata_i;
      next_id_lower_loaded = 1'b1;
    end
    if (wr_rom) begin
      next_rom_image_base_field = reg_wdata_i[31:10];
    end
  end
  // Identity survives software reset; rate is left as it stands
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      link_spd <= nifw_pkg::SPD_RESET;
      node_identity_upper <= nifw_pkg::ID_RESET;
      node_identity_lower <= nifw_pkg::ID_RESET;
      id_upper_loaded <= 1'b0;
      id_lower_loaded <= 1'b0;
      rom_image_base_field <= nifw_pkg::ROM_BASE_RESET[31:10];
      rx_reject <= 1'b0;
    end else begin
      link_spd <= next_link_spd;
      node_identity_upper <= next_node_identity_upper;
      node_identity_lower <= next_node_identity_lower;
      id_upper_loaded <= next_id_upper_loaded;
      id_lower_loaded <= next_id_lower_loaded;
      rom_image_base_field <= next_rom_image_base_field;
      rx_reject <= next_rx_reject;
    end
  end
  // Register read port
  always_comb begin
    next_rvalid = reg_rd_i;
    next_rdata = rdata;
    if (reg_rd_i) begin
      case (reg_addr_i)
        nifw_pkg::OFS_BUS_OPTIONS: next_rdata = {29'h0, link_spd};
        nifw_pkg::OFS_ID_UPPER: next_rdata = node_identity_upper;
        nifw_pkg::OFS_ID_LOWER: next_rdata = node_identity_lower;
        nifw_pkg::OFS_ROM_BASE: next_rdata = {rom_image_base_field, 10'h0};
        nifw_pkg::OFS_LOG_LOWER: next_rdata = (count != '0) ? q_dest[head][31:0] : 32'h0;
        nifw_pkg::OFS_LOG_UPPER: next_rdata = (count != '0) ? {q_req[head], q_dest[head][47:32]} : 32'h0;
        nifw_pkg::OFS_EVENT_SET,
        nifw_pkg::OFS_EVENT_CLEAR: next_rdata = 32'(event_flag) << nifw_pkg::EVENT_FAILED_WRITE_BIT;
        default: next_rdata = 32'h0;
      endcase
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata <= 32'h0;
      rvalid <= 1'b0;
    end else begin
      rdata <= next_rdata;
      rvalid <= next_rvalid;
    end
  end
  // Configuration ROM request mapping
  logic in_rom, rom_local_hit;
  logic rom_fetch, next_rom_fetch, rom_local, next_rom_local, rom_err, next_rom_err;
  logic [31:0] rom_addr, next_rom_addr;
  logic [2:0] rom_idx, next_rom_idx;
  assign in_rom = rom_offset_i >= nifw_pkg::ROM_SPACE_LO && rom_offset_i <= nifw_pkg::ROM_SPACE_HI;
  assign rom_local_hit = rom_offset_i[9:2] < nifw_pkg::ROM_LOCAL_QUADLETS;
  always_comb begin
    next_rom_fetch = 1'b0;
    next_rom_local = 1'b0;
    next_rom_err = 1'b0;
    next_rom_addr = rom_addr;
    next_rom_idx = rom_idx;
    if (rom_req_i && in_rom) begin
      if (!rom_quadlet_read_i) begin
        next_rom_err = 1'b1;
      end else if (rom_local_hit) begin
        next_rom_local = 1'b1;
        next_rom_idx = rom_offset_i[4:2];
      end else begin
        next_rom_fetch = 1'b1;
        next_rom_addr = {rom_image_base_field, 10'h0} + {22'h0, rom_offset_i[9:0]};
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rom_fetch <= 1'b0;
      rom_local <= 1'b0;
      rom_err <= 1'b0;
      rom_addr <= 32'h0;
      rom_idx <= 3'h0;
    end else begin
      rom_fetch <= next_rom_fetch;
      rom_local <= next_rom_local;
      rom_err <= next_rom_err;
      rom_addr <= next_rom_addr;
      rom_idx <= next_rom_idx;
    end
  end
  // Failed-write queue
  logic push, pop;
  assign push = fw_fail_i && (count != DEPTH_C || pop);
  assign pop = clr_event && event_flag;
  always_comb begin
    next_head = head;
    next_tail = tail;
    next_count = count;
    next_fw_drop = fw_fail_i;
    for (int i = 0; i < DEPTH; i++) begin
      next_q_req[i] = q_req[i];
      next_q_dest[i] = q_dest[i];
    end
    if (push) begin
      next_q_req[tail] = fw_requester_i;
      next_q_dest[tail] = fw_dest_i;
      next_tail = (tail == PW'(DEPTH - 1)) ? '0 : tail + 1'b1;
    end
    if (pop) begin
      next_head = (head == PW'(DEPTH - 1)) ? '0 : head + 1'b1;
    end
    next_count = count + (PW+1)'(push) - (PW+1)'(pop);
    // A cleared flag comes back next cycle while entries remain
    if (pop) begin
      next_event_flag = 1'b0;
    end else begin
      next_event_flag = event_flag || (count != '0);
    end
    if (soft_rst_i) begin
      next_head = '0;
      next_tail = '0;
      next_count = '0;
      next_event_flag = 1'b0;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      head <= '0;
      tail <= '0;
      count <= '0;
      event_flag <= 1'b0;
      fw_drop <= 1'b0;
    end else begin
      head <= next_head;
      tail <= next_tail;
      count <= next_count;
      event_flag <= next_event_flag;
      fw_drop <= next_fw_drop;
    end
  end
  generate
    for (genvar g = 0; g < DEPTH; g++) begin : g_entry
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          q_req[g] <= 16'h0;
          q_dest[g] <= 48'h0;
        end else begin
          q_req[g] <= next_q_req[g];
          q_dest[g] <= next_q_dest[g];
        end
      end
    end
  endgenerate
  assign reg_rdata_o = rdata;
  assign reg_rvalid_o = rvalid;
  assign rx_reject_o = rx_reject;
  assign link_spd_o = link_spd;
  assign rom_fetch_o = rom_fetch;
  assign rom_host_addr_o = rom_addr;
  assign rom_local_o = rom_local;
  assign rom_local_index_o = rom_idx;
  assign rom_type_error_o = rom_err;
  assign fw_drop_o = fw_drop;
  assign failed_write_event_o = event_flag;
  // Checks
  sequence s_clear;
    clr_event && event_flag && !soft_rst_i;
  endsequence
  sequence s_rom_fetch_req;
    rom_req_i && in_rom && rom_quadlet_read_i && !rom_local_hit;
  endsequence
  property p_rate_reset;
    @(posedge clk_i) $rose(rst_n_i) |-> link_spd == nifw_pkg::SPD_400;
  endproperty
  a_rate_reset: assert property (p_rate_reset) else $error("rate not 400 after reset");
  property p_rate_legal;
    @(posedge clk_i) disable iff (!rst_n_i) link_spd <= nifw_pkg::SPD_400;
  endproperty
  a_rate_legal: assert property (p_rate_legal) else $error("reserved rate code held");
  property p_rate_protect;
    @(posedge clk_i) disable iff (!rst_n_i)
      wr_spd && spd_write_protect_i && !eeprom_spd_load_i |=> $stable(link_spd);
  endproperty
  a_rate_protect: assert property (p_rate_protect) else $error("protected rate changed");
  property p_reject;
    @(posedge clk_i) disable iff (!rst_n_i)
      rx_pkt_valid_i && rx_pkt_spd_i > link_spd |=> rx_reject_o;
  endproperty
  a_reject: assert property (p_reject) else $error("fast packet not rejected");
  property p_id_lock;
    @(posedge clk_i) disable iff (!rst_n_i)
      id_upper_loaded ##1 (wr_up || eeprom_id_load_i) |=> $stable(node_identity_upper);
  endproperty
  a_id_lock: assert property (p_id_lock) else $error("identity rewritten");
  property p_rom_addr;
    @(posedge clk_i) disable iff (!rst_n_i)
      s_rom_fetch_req |=> rom_fetch_o && !rom_local_o
        && rom_host_addr_o[9:0] == $past(rom_offset_i[9:0])
        && rom_host_addr_o[31:10] == $past(rom_image_base_field);
  endproperty
  a_rom_addr: assert property (p_rom_addr) else $error("rom host address wrong");
  property p_rom_local;
    @(posedge clk_i) disable iff (!rst_n_i)
      rom_req_i && in_rom && rom_quadlet_read_i && rom_local_hit |=> rom_local_o && !rom_fetch_o;
  endproperty
  a_rom_local: assert property (p_rom_local) else $error("header quadlet fetched");
  property p_rom_error;
    @(posedge clk_i) disable iff (!rst_n_i)
      rom_req_i && in_rom && !rom_quadlet_read_i |=> rom_type_error_o && !rom_fetch_o;
  endproperty
  a_rom_error: assert property (p_rom_error) else $error("non-quadlet rom access accepted");
  property p_fw_drop;
    @(posedge clk_i) disable iff (!rst_n_i) fw_fail_i |=> fw_drop_o;
  endproperty
  a_fw_drop: assert property (p_fw_drop) else $error("failed write not dropped");
  property p_fw_advance;
    @(posedge clk_i) disable iff (!rst_n_i)
      s_clear ##1 (count != '0 && !soft_rst_i) |=> failed_write_event_o;
  endproperty
  a_fw_advance: assert property (p_fw_advance) else $error("event not raised for next entry");
  property p_fw_empty;
    @(posedge clk_i) disable iff (!rst_n_i)
      count == '0 && !event_flag |=> !failed_write_event_o;
  endproperty
  a_fw_empty: assert property (p_fw_empty) else $error("event raised with empty queue");
endmodule : nifw_regs

// *** verification/nifw_host_model.sv ***
`timescale 1ns/10ps
module nifw_host_model (
  input wire logic clk_i,
  input wire logic [31:0] reg_rdata_i,
  input wire logic reg_rvalid_i,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_addr_o,
  output logic [31:0] reg_wdata_o
);
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 32'h0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk_i);
    reg_wr_o = 1'b1;
    reg_addr_o = a;
    reg_wdata_o = d;
    @(negedge clk_i);
    reg_wr_o = 1'b0;
    // Idle bus shows no stale value
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic v);
    @(negedge clk_i);
    reg_rd_o = 1'b1;
    reg_addr_o = a;
    @(negedge clk_i);
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    d = reg_rdata_i;
    v = reg_rvalid_i;
  endtask : rd
  task automatic boot(input logic [31:0] hi, input logic [31:0] lo, input logic [31:0] base);
    wr(nifw_pkg::OFS_ID_UPPER, hi);
    wr(nifw_pkg::OFS_ID_LOWER, lo);
    wr(nifw_pkg::OFS_ROM_BASE, base);
  endtask : boot
  task automatic service(output logic [31:0] hi, output logic [31:0] lo);
    logic v;
    rd(nifw_pkg::OFS_LOG_UPPER, hi, v);
    rd(nifw_pkg::OFS_LOG_LOWER, lo, v);
    wr(nifw_pkg::OFS_EVENT_CLEAR, 32'h0000_0100);
  endtask : service
endmodule : nifw_host_model

// *** verification/test_nifw_regs.sv ***
`timescale 1ns/10ps
`define CHK(n, e, g) check(n, 64'(e), 64'(g))
module test_nifw_regs;
  logic clk_i, rst_n_i, soft_rst_i, reg_wr_i, reg_rd_i, reg_rvalid_o, spd_write_protect_i;
  logic eeprom_spd_load_i, eeprom_id_load_i, rx_pkt_valid_i, rx_reject_o, rom_req_i, rom_quadlet_read_i;
  logic rom_fetch_o, rom_local_o, rom_type_error_o, fw_fail_i, fw_drop_o, failed_write_event_o;
  logic [2:0] eeprom_spd_i, rx_pkt_spd_i, link_spd_o, rom_local_index_o;
  logic [7:0] reg_addr_i;
  logic [15:0] fw_requester_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, eeprom_id_upper_i, eeprom_id_lower_i, rom_host_addr_o;
  logic [47:0] rom_offset_i, fw_dest_i;
  logic [31:0] d, idh, idl, base, hi, lo;
  logic [63:0] ent;
  logic [63:0] fq[$];
  logic [47:0] offs[7];
  logic v;
  int failures = 0;
  int check_count = 0;
  int seed = 56780;
  int spd = 2;
  int code;
  int prot;

  nifw_regs u_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .soft_rst_i(soft_rst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .spd_write_protect_i(spd_write_protect_i),
    .eeprom_spd_load_i(eeprom_spd_load_i), .eeprom_spd_i(eeprom_spd_i),
    .eeprom_id_load_i(eeprom_id_load_i), .eeprom_id_upper_i(eeprom_id_upper_i),
    .eeprom_id_lower_i(eeprom_id_lower_i), .rx_pkt_valid_i(rx_pkt_valid_i), .rx_pkt_spd_i(rx_pkt_spd_i),
    .rx_reject_o(rx_reject_o), .link_spd_o(link_spd_o), .rom_req_i(rom_req_i),
    .rom_quadlet_read_i(rom_quadlet_read_i), .rom_offset_i(rom_offset_i), .rom_fetch_o(rom_fetch_o),
    .rom_host_addr_o(rom_host_addr_o), .rom_local_o(rom_local_o), .rom_local_index_o(rom_local_index_o),
    .rom_type_error_o(rom_type_error_o), .fw_fail_i(fw_fail_i), .fw_requester_i(fw_requester_i),
    .fw_dest_i(fw_dest_i), .fw_drop_o(fw_drop_o), .failed_write_event_o(failed_write_event_o));
  nifw_host_model u_host (.clk_i(clk_i), .reg_rdata_i(reg_rdata_o), .reg_rvalid_i(reg_rvalid_o),
    .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic check(input string n, input logic [63:0] e, input logic [63:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %0h seen %0h", n, e, g);
    end
  endtask : check
  task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
    u_host.rd(a, d, v);
    `CHK({n, "_valid"}, 1'b1, v);
    `CHK(n, e, d);
  endtask : rdchk
  task automatic pulse(ref logic s);
    @(negedge clk_i);
    s = 1'b1;
    @(negedge clk_i);
    s = 1'b0;
  endtask : pulse
  task automatic print_verdict();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  initial begin
    #(40 * 20000);
    failures++;
    print_verdict();
  end

  initial begin
    {rst_n_i, soft_rst_i, spd_write_protect_i, eeprom_spd_load_i, eeprom_id_load_i} = '0;
    {rx_pkt_valid_i, rom_req_i, rom_quadlet_read_i, fw_fail_i} = '0;
    {eeprom_spd_i, rx_pkt_spd_i, fw_requester_i} = '0;
    {eeprom_id_upper_i, eeprom_id_lower_i, rom_offset_i, fw_dest_i} = '0;
    repeat (5) @(negedge clk_i);
    rst_n_i = 1'b1;
    u_host.rd(nifw_pkg::OFS_BUS_OPTIONS, d, v);
    `CHK("rate_reset", nifw_pkg::SPD_RESET, d[2:0]);
    rdchk("id_hi_reset", nifw_pkg::OFS_ID_UPPER, 32'h0);
    rdchk("id_lo_reset", nifw_pkg::OFS_ID_LOWER, 32'h0);
    rdchk("log_empty", nifw_pkg::OFS_LOG_UPPER, 32'h0);
    idh = $random(seed) | 32'h1;
    idl = $random(seed);
    base = $random(seed);
    u_host.boot(idh, idl, base);
    eeprom_id_upper_i = ~idh;
    eeprom_id_lower_i = ~idl;
    pulse(eeprom_id_load_i);
    u_host.wr(nifw_pkg::OFS_ID_LOWER, ~idl);
    pulse(soft_rst_i);
    rdchk("id_hi", nifw_pkg::OFS_ID_UPPER, idh);
    rdchk("id_lo", nifw_pkg::OFS_ID_LOWER, idl);
    rdchk("rom_base", nifw_pkg::OFS_ROM_BASE, base & 32'hFFFF_FC00);
    for (int i = 0; i < 8; i++) begin
      code = {$random(seed)} % 3;
      prot = {$random(seed)} % 2;
      spd_write_protect_i = prot[0];
      u_host.wr(nifw_pkg::OFS_BUS_OPTIONS, 32'(code));
      if (prot == 0 && code <= spd) spd = code;
      `CHK("link_spd", spd, link_spd_o);
      for (int s = 0; s < 4; s++) begin
        rx_pkt_spd_i = 3'(s);
        pulse(rx_pkt_valid_i);
        `CHK("reject", s > spd, rx_reject_o);
      end
    end
    eeprom_spd_i = nifw_pkg::SPD_400;
    pulse(eeprom_spd_load_i);
    `CHK("eeprom_spd", nifw_pkg::SPD_400, link_spd_o);
    offs = '{48'hFFFF_F000_0420, 48'hFFFF_F000_0404, 48'hFFFF_F000_0410, 48'hFFFF_F000_0414,
      48'hFFFF_F000_07FC, 48'hFFFF_F000_0800, 48'hFFFF_F000_03FC};
    for (int i = 0; i < 14; i++) begin
      rom_offset_i = offs[i % 7];
      rom_quadlet_read_i = (i < 7);
      pulse(rom_req_i);
      v = rom_offset_i >= nifw_pkg::ROM_SPACE_LO && rom_offset_i <= nifw_pkg::ROM_SPACE_HI;
      ent = !v ? 0 : !rom_quadlet_read_i ? 1 : rom_offset_i[9:0] < 10'h014 ? 2 : 4;
      `CHK("rom_kind", ent, {rom_fetch_o, rom_local_o, rom_type_error_o});
      if (ent == 4) `CHK("rom_addr", (base & 32'hFFFF_FC00) + rom_offset_i[9:0], rom_host_addr_o);
      if (ent == 2) `CHK("rom_idx", rom_offset_i[9:2], rom_local_index_o);
    end
    for (int i = 0; i < 6; i++) begin
      fw_requester_i = $random(seed);
      fw_dest_i = 48'({$random(seed), $random(seed)});
      if (fq.size() < nifw_pkg::LOG_DEPTH) fq.push_back({fw_requester_i, fw_dest_i});
      pulse(fw_fail_i);
      `CHK("drop", 1'b1, fw_drop_o);
    end
    `CHK("event_set", 1'b1, failed_write_event_o);
    while (fq.size() > 0) begin
      ent = fq.pop_front();
      rdchk("log_hold", nifw_pkg::OFS_LOG_LOWER, ent[31:0]);
      u_host.service(hi, lo);
      `CHK("log_hi", ent[63:32], hi);
      `CHK("log_lo", ent[31:0], lo);
      `CHK("event_drop", 1'b0, failed_write_event_o);
      @(negedge clk_i);
      `CHK("event_next", fq.size() > 0, failed_write_event_o);
    end
    rdchk("log_drained", nifw_pkg::OFS_LOG_LOWER, 32'h0);
    print_verdict();
  end
endmodule : test_nifw_regs
